// ===== hdl/acc_top.sv
/*
 * Converter control block: control register, sample and conversion
 * sequencing, trigger selection and result formatting.
 * Assumes an analog core that takes a start pulse and answers with a done
 * pulse and a 10-bit result, and a register master that never waits.
 */
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module acc_top #(
	parameter int SAMPLE_CYC = acc_pkg::ACC_AUTO_SAMPLE_CYC,
	parameter bit PIN_RISING = 1'b1
) (
	input wire logic clk, // 40 MHz system clock
	input wire logic srst, // synchronous reset, active high
	input wire logic [7:0] reg_addr, // register byte offset
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	input wire logic idle_mode, // system is in idle mode
	input wire logic ext_interrupt_pin_zero, // interrupt pin zero
	input wire logic timer3_match, // timer 3 period match pulse
	input wire logic charge_time_unit, // charge-time unit pulse
	input wire logic core_done, // analog core finished, pulse
	input wire logic [acc_pkg::ACC_RAW_W-1:0] core_data, // core result
	output logic sample_en, // hold the sampling switch closed
	output logic conv_start, // start conversion, one-cycle pulse
	output logic conv_done, // mirrors the done flag
	output logic [31:0] result_word // formatted result
);
	import acc_pkg::*;

	acc_conv_if cif ();

	// control register fields
	logic on_r, on_nxt;
	logic halt_idle_r, halt_idle_nxt;
	logic [2:0] result_format_sel_r, result_format_sel_nxt;
	logic [2:0] trig_sel_r, trig_sel_nxt;
	logic one_shot_r, one_shot_nxt;
	logic auto_r, auto_nxt;
	logic done_r, done_nxt;

	// sequencer and port registers
	acc_state_e st_r, st_nxt;
	logic start_r, start_nxt;
	logic sample_out_r, sample_out_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	// decoded strobes
	logic ctrl_wr;
	logic active;
	logic sample_set_req;
	logic sample_clr_req;
	logic start_now;
	logic done_clr;
	logic done_set;
	logic [31:0] ctrl_view;

	// decode of the register strobes and the run condition
	always_comb begin
		ctrl_wr = reg_wr && (reg_addr == ACC_CTRL_OFFS);
		active = on_r && !(halt_idle_r && idle_mode);
		sample_set_req = ctrl_wr && reg_wdata[ACC_SAMPLE_BIT];
		sample_clr_req = ctrl_wr && !reg_wdata[ACC_SAMPLE_BIT];
		// write of zero clears, write of one ignored
		done_clr = ctrl_wr && !reg_wdata[ACC_DONE_BIT];
	end

	// readback image of the control register
	always_comb begin
		ctrl_view = 32'h0000_0000;
		ctrl_view[ACC_ON_BIT] = on_r;
		ctrl_view[ACC_HALT_IDLE_BIT] = halt_idle_r;
		ctrl_view[ACC_RESULT_FORMAT_SEL_LSB +: 3] = result_format_sel_r;
		ctrl_view[ACC_TRIG_SEL_LSB +: 3] = trig_sel_r;
		ctrl_view[ACC_ONE_SHOT_BIT] = one_shot_r;
		ctrl_view[ACC_AUTO_SAMPLE_BIT] = auto_r;
		ctrl_view[ACC_SAMPLE_BIT] = (st_r == ACC_ST_SAMPLE);
		ctrl_view[ACC_DONE_BIT] = done_r;
	end

	// sample / convert sequencer
	always_comb begin
		st_nxt = st_r;
		start_now = 1'b0;
		done_set = 1'b0;
		if (!active) begin
			// a disabled or idled module drops any sampling or conversion
			st_nxt = ACC_ST_IDLE;
		end else begin
			case (st_r)
				ACC_ST_IDLE: begin
					if (auto_r || sample_set_req)
						st_nxt = ACC_ST_SAMPLE;
				end
				ACC_ST_SAMPLE: begin
					if (trig_sel_r == ACC_TRG_SWCLR) begin
						if (sample_clr_req) begin
							st_nxt = ACC_ST_CONVERT;
							start_now = 1'b1;
						end
					end else if (cif.fire) begin
						st_nxt = ACC_ST_CONVERT;
						start_now = 1'b1;
					end else if (sample_clr_req && !auto_r) begin
						// manual abort of sampling without a conversion
						st_nxt = ACC_ST_IDLE;
					end
				end
				ACC_ST_CONVERT: begin
					if (core_done) begin
						done_set = 1'b1;
						st_nxt = (auto_r && !one_shot_r) ? ACC_ST_SAMPLE
							: ACC_ST_IDLE;
					end
				end
				default: st_nxt = ACC_ST_IDLE;
			endcase
		end
		start_nxt = start_now;
		sample_out_nxt = (st_nxt == ACC_ST_SAMPLE);
	end

	// control field next values
	always_comb begin
		on_nxt = on_r;
		halt_idle_nxt = halt_idle_r;
		result_format_sel_nxt = result_format_sel_r;
		trig_sel_nxt = trig_sel_r;
		one_shot_nxt = one_shot_r;
		auto_nxt = auto_r;
		if (ctrl_wr) begin
			on_nxt = reg_wdata[ACC_ON_BIT];
			halt_idle_nxt = reg_wdata[ACC_HALT_IDLE_BIT];
			result_format_sel_nxt = reg_wdata[ACC_RESULT_FORMAT_SEL_LSB +: 3];
			trig_sel_nxt = reg_wdata[ACC_TRIG_SEL_LSB +: 3];
			one_shot_nxt = reg_wdata[ACC_ONE_SHOT_BIT];
			auto_nxt = reg_wdata[ACC_AUTO_SAMPLE_BIT];
		end else if (done_set && one_shot_r) begin
			// one-shot auto sampling: stop after the first result
			auto_nxt = 1'b0;
		end
		// a late set still wins over a software clear
		if (done_set)
			done_nxt = 1'b1;
		else if (start_now || done_clr)
			done_nxt = 1'b0;
		else
			done_nxt = done_r;
	end

	// read port: data stand one cycle after the strobe only
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				ACC_CTRL_OFFS: rdata_nxt = ctrl_view;
				ACC_RESULT_OFFS: rdata_nxt = cif.result;
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			on_r <= ACC_CTRL_RESET[ACC_ON_BIT];
			halt_idle_r <= ACC_CTRL_RESET[ACC_HALT_IDLE_BIT];
			result_format_sel_r <= ACC_CTRL_RESET[ACC_RESULT_FORMAT_SEL_LSB +: 3];
			trig_sel_r <= ACC_CTRL_RESET[ACC_TRIG_SEL_LSB +: 3];
			one_shot_r <= ACC_CTRL_RESET[ACC_ONE_SHOT_BIT];
			auto_r <= ACC_CTRL_RESET[ACC_AUTO_SAMPLE_BIT];
			done_r <= ACC_CTRL_RESET[ACC_DONE_BIT];
			st_r <= ACC_ST_IDLE;
			start_r <= 1'b0;
			sample_out_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			on_r <= on_nxt;
			halt_idle_r <= halt_idle_nxt;
			result_format_sel_r <= result_format_sel_nxt;
			trig_sel_r <= trig_sel_nxt;
			one_shot_r <= one_shot_nxt;
			auto_r <= auto_nxt;
			done_r <= done_nxt;
			st_r <= st_nxt;
			start_r <= start_nxt;
			sample_out_r <= sample_out_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// bundle to the helpers; the result is caught as the core reports it
	assign cif.trig_sel = trig_sel_r;
	assign cif.sampling = (st_r == ACC_ST_SAMPLE);
	assign cif.active = active;
	assign cif.fmt_sel = result_format_sel_r;
	assign cif.raw = core_data;
	assign cif.raw_load = done_set;

	acc_trigger #(
		.SAMPLE_CYC(SAMPLE_CYC),
		.PIN_RISING(PIN_RISING)
	) u_trigger (
		.clk(clk),
		.srst(srst),
		.ext_interrupt_pin_zero(ext_interrupt_pin_zero),
		.timer3_match(timer3_match),
		.charge_time_unit(charge_time_unit),
		.cif(cif)
	);

	acc_format u_format (
		.clk(clk),
		.srst(srst),
		.cif(cif)
	);

	// every output straight from a flip-flop
	assign reg_rdata = rdata_r;
	assign sample_en = sample_out_r;
	assign conv_start = start_r;
	assign conv_done = done_r;
	assign result_word = cif.result;
endmodule

// ===== common/acc_pkg.sv
/*
 * Constants shared by the converter control block: register offsets, field
 * positions, reset values, trigger and format codes, sampling time.
 * Assumes a 40 MHz clock and a 32-bit register port with byte offsets.
 */
// Overview of operation
// - converter runs only while the module enable bit 15 is set.
// - stop-in-idle bit 13 set halts operation while the system is idle.
// - formats 000 and 100 give the result right-justified, zero filled.
// - format 101 gives the result right-justified, sign extended to 32 bits.
// - formats 010/011 left-align in the low half; 011 has a sign bit.
// - formats 110/111 left-align at the word top; 111 has a sign bit.
// - trigger 111 uses an internal counter; codes 100 to 110 trigger nothing.
// - trigger 011 takes the charge-time unit event.
// - trigger 010 takes the timer 3 period match.
// - trigger 001 takes an active transition on interrupt pin zero.
// - trigger 000 starts conversion when the sample bit is cleared.
// - with auto-sample on, hardware sets the sample bit itself.
// - with any other trigger, hardware clears the sample bit at the trigger.
// - done flag bit 0 sets at conversion end, clears at the next start.
// - software clears done by writing 0; the clear leaves conversions alone.
// - bits 31 to 16, 14, 12, 11 and 3 read as zero.
package acc_pkg;
	localparam logic [7:0] ACC_CTRL_OFFS = 8'h00;
	localparam logic [7:0] ACC_RESULT_OFFS = 8'h04;
	localparam logic [31:0] ACC_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] ACC_RESULT_RESET = 32'h0000_0000;
	localparam int ACC_ON_BIT = 15;
	localparam int ACC_HALT_IDLE_BIT = 13;
	localparam int ACC_RESULT_FORMAT_SEL_LSB = 8;
	localparam int ACC_TRIG_SEL_LSB = 5;
	localparam int ACC_ONE_SHOT_BIT = 4;
	localparam int ACC_AUTO_SAMPLE_BIT = 2;
	localparam int ACC_SAMPLE_BIT = 1;
	localparam int ACC_DONE_BIT = 0;
	localparam int ACC_RAW_W = 10;
	localparam logic [2:0] ACC_TRG_SWCLR = 3'h0;
	localparam logic [2:0] ACC_TRG_PIN0 = 3'h1;
	localparam logic [2:0] ACC_TRG_TMR3 = 3'h2;
	localparam logic [2:0] ACC_TRG_CTU = 3'h3;
	localparam logic [2:0] ACC_TRG_AUTO = 3'h7;
	localparam logic [2:0] ACC_FMT_INT16 = 3'h0;
	localparam logic [2:0] ACC_FMT_FRAC16 = 3'h2;
	localparam logic [2:0] ACC_FMT_SFRAC16 = 3'h3;
	localparam logic [2:0] ACC_FMT_INT32 = 3'h4;
	localparam logic [2:0] ACC_FMT_SINT32 = 3'h5;
	localparam logic [2:0] ACC_FMT_FRAC32 = 3'h6;
	localparam logic [2:0] ACC_FMT_SFRAC32 = 3'h7;
	localparam int ACC_CLK_PERIOD_PS = 25000;
	localparam int ACC_AUTO_SAMPLE_NS = 200;
	localparam int ACC_AUTO_SAMPLE_CYC =
		(ACC_AUTO_SAMPLE_NS * 1000 + ACC_CLK_PERIOD_PS - 1) / ACC_CLK_PERIOD_PS;
	typedef enum logic [1:0] {
		ACC_ST_IDLE = 2'h0,
		ACC_ST_SAMPLE = 2'h1,
		ACC_ST_CONVERT = 2'h3
	} acc_state_e;
endpackage

// ===== common/acc_conv_if.sv
/*
 * Bundle joining the control core to its trigger selector and result
 * formatter. Assumes all three parties run on the same clock.
 */
`timescale 1ns/1ps
interface acc_conv_if;
	logic [2:0] trig_sel;
	logic sampling;
	logic active;
	logic fire;
	logic [2:0] fmt_sel;
	logic [9:0] raw;
	logic raw_load;
	logic [31:0] result;
	modport ctl (output trig_sel, sampling, active, fmt_sel, raw, raw_load,
		input fire, result);
	modport trg (input trig_sel, sampling, active, output fire);
	modport fmt (input fmt_sel, raw, raw_load, output result);
endinterface

// ===== hdl/acc_trigger.sv
/*
 * Trigger selector: turns the chosen hardware source into a one-cycle fire
 * pulse that ends sampling. Assumes source inputs are synchronous to clk.
 */
`timescale 1ns/1ps
module acc_trigger #(
	parameter int SAMPLE_CYC = acc_pkg::ACC_AUTO_SAMPLE_CYC,
	parameter bit PIN_RISING = 1'b1
) (
	input wire logic clk, // system clock
	input wire logic srst, // synchronous reset
	input wire logic ext_interrupt_pin_zero, // interrupt pin zero level
	input wire logic timer3_match, // timer 3 period match pulse
	input wire logic charge_time_unit, // charge-time unit trigger pulse
	acc_conv_if.trg cif // control bundle
);
	import acc_pkg::*;
	logic [15:0] cnt_r, cnt_nxt;
	logic pin_r, pin_nxt;
	logic fire_r, fire_nxt;
	logic pin_edge;

	// source selection; reserved codes fall through to no trigger
	always_comb begin
		pin_nxt = ext_interrupt_pin_zero;
		pin_edge = PIN_RISING ? (ext_interrupt_pin_zero & ~pin_r)
			: (~ext_interrupt_pin_zero & pin_r);
		cnt_nxt = cif.sampling ? cnt_r : 16'h0000;
		if (cif.sampling && cnt_r != 16'(SAMPLE_CYC))
			cnt_nxt = cnt_r + 16'h0001;
		fire_nxt = 1'b0;
		if (cif.active && cif.sampling && !fire_r) begin
			case (cif.trig_sel)
				ACC_TRG_PIN0: fire_nxt = pin_edge;
				ACC_TRG_TMR3: fire_nxt = timer3_match;
				ACC_TRG_CTU: fire_nxt = charge_time_unit;
				ACC_TRG_AUTO: fire_nxt = (cnt_r == 16'(SAMPLE_CYC - 1));
				default: fire_nxt = 1'b0;
			endcase
		end
	end

	// registers only
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_r <= 16'h0000;
			pin_r <= 1'b0;
			fire_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			pin_r <= pin_nxt;
			fire_r <= fire_nxt;
		end
	end

	assign cif.fire = fire_r;
endmodule

// ===== hdl/acc_format.sv
/*
 * Result formatter: lays the 10-bit conversion result out in a 32-bit word
 * in the selected format. Assumes the core delivers offset binary.
 */
`timescale 1ns/1ps
module acc_format (
	input wire logic clk, // system clock
	input wire logic srst, // synchronous reset
	acc_conv_if.fmt cif // control bundle
);
	import acc_pkg::*;
	logic [31:0] res_r, res_nxt;
	logic [9:0] sdat;

	// signed formats flip the msb so mid-scale reads as zero
	always_comb begin
		sdat = {~cif.raw[9], cif.raw[8:0]};
		res_nxt = res_r;
		if (cif.raw_load) begin
			case (cif.fmt_sel)
				ACC_FMT_SINT32: res_nxt = {{22{sdat[9]}}, sdat};
				ACC_FMT_FRAC16: res_nxt = {16'h0000, cif.raw, 6'h00};
				ACC_FMT_SFRAC16: res_nxt = {16'h0000, sdat, 6'h00};
				ACC_FMT_FRAC32: res_nxt = {cif.raw, 22'h000000};
				ACC_FMT_SFRAC32: res_nxt = {sdat, 22'h000000};
				// zero filled; reserved code lands here
				default: res_nxt = {22'h000000, cif.raw};
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			res_r <= ACC_RESULT_RESET;
		else
			res_r <= res_nxt;
	end

	assign cif.result = res_r;
endmodule

// ===== test/acc_top_checker.sv
/* assertions for the converter control block
 assumes it is bound into acc_top and sees only its ports */
`timescale 1ns/1ps
module acc_top_checker
	import acc_pkg::*;
#(
	parameter int SAMPLE_CYC = 8
) (
	input wire logic clk, // clock
	input wire logic srst, // reset
	input wire logic [7:0] reg_addr, // offset
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [31:0] reg_rdata, // read data
	input wire logic idle_mode, // idle level
	input wire logic timer3_match, // timer event
	input wire logic core_done, // core finished
	input wire logic sample_en, // sampling
	input wire logic conv_start, // start pulse
	input wire logic conv_done // done flag
);
	logic [15:0] cr_r;
	logic [15:0] cr_nxt;
	logic on_q;
	logic halt_q;
	logic res_q;
	// mirror of software-owned fields only; hardware-set bits are not needed here
	always_comb begin
		cr_nxt = cr_r;
		if (reg_wr && reg_addr == ACC_CTRL_OFFS) begin
			cr_nxt = reg_wdata[15:0];
		end
	end
	always_ff @(posedge clk) begin
		cr_r <= srst ? 16'h0 : cr_nxt;
	end
	assign on_q = cr_r[ACC_ON_BIT];
	assign halt_q = cr_r[ACC_HALT_IDLE_BIT] && idle_mode;
	assign res_q = cr_r[7] && cr_r[7:5] != ACC_TRG_AUTO;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_ctrl_reserved_zero: assert property (
		reg_rd && reg_addr == ACC_CTRL_OFFS |=> (reg_rdata & 32'hffff_5808) == 32'h0)
		else $error("unimplemented control bits read nonzero");
	a_start_one_cycle: assert property (conv_start |=> !conv_start)
		else $error("start pulse longer than one cycle");
	a_start_ends_sample: assert property (conv_start |-> !sample_en)
		else $error("sampling still on at start");
	a_start_clears_done: assert property (conv_start |-> !conv_done)
		else $error("done flag kept at new start");
	a_done_needs_core: assert property ($rose(conv_done) |-> $past(core_done))
		else $error("done flag rose without core finish");
	a_off_holds_idle: assert property (
		!$past(on_q) |-> !sample_en && !conv_start)
		else $error("activity while disabled");
	a_idle_halts_all: assert property (
		$past(halt_q) |-> !sample_en && !conv_start)
		else $error("activity while halted in idle");
	a_tmr_fires_start: assert property (
		on_q && !halt_q && sample_en && cr_r[7:5] == ACC_TRG_TMR3 && timer3_match
		|-> ##2 conv_start)
		else $error("timer event did not start conversion");
	a_reserved_quiet: assert property (
		res_q && $past(res_q) && $past(res_q, 2) |-> !conv_start)
		else $error("reserved trigger started conversion");
endmodule
bind acc_top acc_top_checker #(.SAMPLE_CYC(SAMPLE_CYC)) u_chk (
	.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_mode(idle_mode),
	.timer3_match(timer3_match), .core_done(core_done), .sample_en(sample_en),
	.conv_start(conv_start), .conv_done(conv_done)
);

// ===== test/acc_core_model.sv
/* behavioural analog core: start pulse in, done pulse and data out
 assumes a one-cycle start pulse on the block clock */
`timescale 1ns/1ps
module acc_core_model (
	input wire logic clk, // clock
	input wire logic conv_start, // start pulse
	input wire logic slow, // long conversion
	input wire logic [9:0] value, // level to convert
	output logic core_done, // done pulse
	output logic [9:0] core_data // valid only with done
);
	int cnt = 0;
	initial begin
		core_done = 1'b0;
		core_data = 10'h0;
	end
	// data toggles outside the done cycle so a stale capture cannot pass
	always @(posedge clk) begin
		core_done <= cnt == 1;
		core_data <= cnt == 1 ? value : ~core_data;
		cnt <= conv_start ? (slow ? 6 : 1) : (cnt > 0 ? cnt - 1 : 0);
	end
endmodule

// ===== test/tb_acc_top.sv
/* self-checking bench for the converter control block
 assumes the core model above and the default 8-cycle auto sample time */
`timescale 1ns/1ps
module tb_acc_top;
	import acc_pkg::*;
	logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, idle_mode = 0;
	logic pin0 = 0, tmr = 0, ctu = 0, slow = 0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, result_word, d;
	logic [9:0] raw = 10'h0, core_data;
	logic core_done, sample_en, conv_start, conv_done;
	int n_mismatch = 0, cmp_count = 0, n_start = 0;
	acc_top #(.SAMPLE_CYC(8), .PIN_RISING(1'b1)) u_dut (
		.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_mode(idle_mode),
		.ext_interrupt_pin_zero(pin0), .timer3_match(tmr), .charge_time_unit(ctu),
		.core_done(core_done), .core_data(core_data), .sample_en(sample_en),
		.conv_start(conv_start), .conv_done(conv_done), .result_word(result_word)
	);
	acc_core_model u_core (.clk(clk), .conv_start(conv_start), .slow(slow), .value(raw),
		.core_done(core_done), .core_data(core_data));
	always #12.5 clk = ~clk;
	// start pulses are counted so that missing and extra ones both show
	always @(posedge clk) begin
		if (conv_start === 1'b1) n_start <= n_start + 1;
	end
	task automatic summarize();
		$display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
	endtask
	task automatic pulse(input logic [2:0] s);
		@(posedge clk);
		{ctu, tmr, pin0} <= s;
		@(posedge clk);
		{ctu, tmr, pin0} <= 3'h0;
	endtask
	// bounded wait on sample_en (sel 0) or conv_done (sel 1)
	task automatic wait_hi(input logic sel);
		cmp_count++;
		for (int i = 0; i < 40; i++) begin
			@(negedge clk);
			if ((sel ? conv_done : sample_en) === 1'b1) return;
		end
		n_mismatch++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		summarize();
	endtask
	function automatic logic [31:0] fmt_exp(input logic [2:0] f, input logic [9:0] r);
		logic [9:0] s;
		s = {~r[9], r[8:0]};
		case (f)
			3'h2: return {16'h0, r, 6'h0};
			3'h3: return {16'h0, s, 6'h0};
			3'h5: return {{22{s[9]}}, s};
			3'h6: return {r, 22'h0};
			3'h7: return {s, 22'h0};
			default: return {22'h0, r};
		endcase
	endfunction
	initial begin
		logic [2:0] src;
		int n0;
		void'($urandom(32'h2463745a));
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rd(ACC_CTRL_OFFS, d);
		chk(d, ACC_CTRL_RESET);
		wr(ACC_CTRL_OFFS, 32'hffff_7ffc);
		rd(ACC_CTRL_OFFS, d);
		chk(d, 32'h0000_27f4);
		wr(8'h08, 32'hffff_ffff);
		rd(8'h08, d);
		chk(d, 32'h0);
		wr(ACC_CTRL_OFFS, 32'h8000);
		// manual sampling through every format, random data and latency
		for (int f = 0; f < 8; f++) begin
			raw <= 10'($urandom);
			slow <= 1'($urandom);
			idle_mode <= f[0];
			wr(ACC_CTRL_OFFS, 32'h8002 | 32'(f << 8));
			wait_hi(1'b0);
			chk(32'(conv_done), 32'h0);
			wr(ACC_CTRL_OFFS, 32'h8000 | 32'(f << 8));
			@(negedge clk);
			chk(32'({conv_start, sample_en}), 32'h2);
			if (slow) begin
				wr(ACC_CTRL_OFFS, 32'h8000 | 32'(f << 8));
			end
			wait_hi(1'b1);
			chk(result_word, fmt_exp(3'(f), raw));
			rd(ACC_RESULT_OFFS, d);
			chk(d, fmt_exp(3'(f), raw));
			rd(ACC_CTRL_OFFS, d);
			chk(d, 32'h8001 | 32'(f << 8));
		end
		// hardware triggers: foreign sources first, then the chosen one
		for (int t = 1; t < 8; t++) begin
			src = t < 4 ? 3'(1 << (t - 1)) : 3'h0;
			n0 = n_start;
			wr(ACC_CTRL_OFFS, 32'h8000 | 32'(t << 5));
			wr(ACC_CTRL_OFFS, 32'h8002 | 32'(t << 5));
			wait_hi(1'b0);
			pulse(~src);
			repeat (2) @(negedge clk);
			chk(32'(n_start - n0), 32'h0);
			pulse(src);
			repeat (12) @(negedge clk);
			chk(32'(n_start - n0), (t > 3 && t < 7) ? 32'h0 : 32'h1);
			wr(ACC_CTRL_OFFS, 32'h0);
		end
		// auto sampling, idle kept running, then halted by stop-in-idle
		wr(ACC_CTRL_OFFS, 32'h80e0);
		wr(ACC_CTRL_OFFS, 32'h80e4);
		wait_hi(1'b0);
		wait_hi(1'b1);
		wait_hi(1'b0);
		wr(ACC_CTRL_OFFS, 32'ha0e4);
		repeat (2) @(negedge clk);
		chk(32'({sample_en, conv_start}), 32'h0);
		@(posedge clk);
		idle_mode <= 1'b0;
		wait_hi(1'b0);
		summarize();
	end
endmodule
